// >>> inc/cqd_pkg.sv
// Constants and carrier types for the completion head doorbell and indirect access block
package cqd_pkg;
  // Queue count and head width
  localparam int CQD_NUM_CQ = 4;
  localparam int CQD_QW = 2;
  localparam int CQD_HEAD_W = 16;
  localparam int CQD_HEAD_LSB = 0;
  // Memory-mapped doorbell area
  localparam logic [31:0] CQD_DB_BASE = 32'h0000_1000;
  localparam logic [31:0] CQD_DB_READ_VALUE = 32'h0000_0000;
  localparam logic [31:0] CQD_DWORD_BYTES = 32'h0000_0004;
  localparam logic [4:0] CQD_DWORD_SHIFT = 5'h02;
  // I/O space pair
  localparam logic [31:0] CQD_IO_SELECT_OFF = 32'h0000_0000;
  localparam logic [31:0] CQD_IO_WINDOW_OFF = 32'h0000_0004;
  localparam int CQD_SEL_LSB = 2;
  localparam logic [31:0] CQD_SEL_MASK = 32'hFFFF_FFFC;
  // Reset values
  localparam logic [31:0] CQD_SELECT_RST = 32'h0000_0000;
  localparam logic [15:0] CQD_HEAD_RST = 16'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cqd_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } cqd_rsp_t;

  typedef struct packed {
    logic valid;
    logic [CQD_QW-1:0] qid;
    logic [16:0] freed;
  } cqd_free_t;

  typedef struct packed {
    logic valid;
    logic [CQD_QW-1:0] qid;
  } cqd_evt_t;
endpackage

// >>> logic/cqd_top.sv
// Completion head doorbells with an I/O space indirect select/window pair
//
// What this block does
// RULE1: Completion queue y head doorbell sits at 1000h plus (2y+1) times (4 shifted left by the stride field).
// RULE2: Doorbells should not be read by software, and a read here returns a fixed value of no meaning.
// RULE3: Software never writes the head doorbell of a queue that does not exist.
// RULE4: Software keeps draining every completion queue regardless of submission queue occupancy.
// RULE5: A write to head bits 15:0 replaces the stored head pointer, and bits 31:16 read as zero; the code ignores head values above cq_size.
// RULE6: The wrap-aware difference between the old and new head is reported as the number of freed slots.
// RULE7: The select/window pair is decoded in the I/O space window and reaches every memory-mapped register.
// RULE8: Software does not alternate between indirect and direct access.
// RULE9: After any direct access software stops using the indirect pair.
// RULE10: The select register at 00h holds the dword offset in bits 31:2, with bits 1:0 reading as zero.
// RULE11: Software never loads the select register beyond the highest implemented offset.
// RULE12: Window accesses at 04h are forwarded to the register named by the select, and the window stores nothing.
// RULE13: After reset a window read returns the reset value of the register currently selected.
// RULE14: Head pointer arithmetic wraps to zero at the queue size.
// RULE15: An invalid doorbell value written while an event request is pending raises an invalid-doorbell event.
// RULE16: Select writes ignore bits 1:0 and every window access is a whole dword.
module cqd_top
  import cqd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Direct memory-mapped access
  input wire cqd_req_t mmio_req,
  output logic mmio_ready,
  output cqd_rsp_t mmio_rsp,
  // I/O space access
  input wire cqd_req_t io_req,
  output cqd_rsp_t io_rsp,
  // Other memory-mapped registers
  output cqd_req_t ext_req,
  input wire logic [31:0] ext_rdata,
  // Queue configuration and status
  input wire logic [3:0] doorbell_stride_field,
  input wire logic [CQD_NUM_CQ-1:0][15:0] cq_size,
  input wire logic aer_pending,
  output logic [CQD_NUM_CQ-1:0][15:0] completion_head_value,
  output cqd_free_t freed_o,
  output cqd_evt_t inv_db_o
);
  logic [31:0] sel_r, sel_nxt;
  logic [15:0] head_r [CQD_NUM_CQ];
  logic [15:0] head_nxt [CQD_NUM_CQ];
  cqd_free_t freed_r, freed_nxt;
  cqd_evt_t evt_r, evt_nxt;
  cqd_rsp_t mrsp_r, mrsp_nxt, irsp_r, irsp_nxt;

  cqd_req_t acc;
  logic io_sel_hit, io_win_hit;
  logic [31:0] off, idx, stride_mask, qid_full, acc_rdata;
  logic [4:0] shamt;
  logic db_hit, db_wr;
  logic [CQD_QW-1:0] qsel;
  logic [15:0] new_head, old_head;
  logic [16:0] size_sel, freed_cnt;
  logic val_ok;

  // Internal access: window has priority over direct access
  always_comb
  begin
    io_sel_hit = io_req.valid && (io_req.addr == CQD_IO_SELECT_OFF);
    io_win_hit = io_req.valid && (io_req.addr == CQD_IO_WINDOW_OFF); // RULE7
    mmio_ready = !io_win_hit;
    if (io_win_hit)
    begin
      acc.valid = 1'b1; // RULE12
      acc.write = io_req.write;
      acc.addr = sel_r & CQD_SEL_MASK; // RULE16
      acc.wdata = io_req.wdata;
    end
    else
    begin
      acc = mmio_req;
    end
  end

  // Doorbell decode
  always_comb
  begin
    off = acc.addr - CQD_DB_BASE;
    shamt = {1'b0, doorbell_stride_field} + CQD_DWORD_SHIFT;
    stride_mask = (CQD_DWORD_BYTES << doorbell_stride_field) - 32'h0000_0001;
    idx = off >> shamt;
    qid_full = idx >> 1;
    qsel = qid_full[CQD_QW-1:0];
    db_hit = acc.valid && (acc.addr >= CQD_DB_BASE) && ((off & stride_mask) == 32'h0000_0000)
      && idx[0] && (qid_full < 32'(CQD_NUM_CQ)); // RULE1
    db_wr = db_hit && acc.write;
    new_head = acc.wdata[CQD_HEAD_LSB +: CQD_HEAD_W]; // RULE5
    old_head = head_r[qsel];
    size_sel = {1'b0, cq_size[qsel]} + 17'h00001;
    val_ok = {1'b0, new_head} < size_sel;
    if (new_head >= old_head) // RULE14
      freed_cnt = {1'b0, new_head} - {1'b0, old_head};
    else
      freed_cnt = {1'b0, new_head} + size_sel - {1'b0, old_head}; // RULE6
    acc_rdata = db_hit ? CQD_DB_READ_VALUE : ext_rdata; // RULE2
    ext_req = acc;
    ext_req.valid = acc.valid && !db_hit;
  end

  // Per-queue head registers
  for (genvar i = 0; i < CQD_NUM_CQ; i++)
  begin : g_head
    always_comb
    begin
      head_nxt[i] = head_r[i];
      if (db_wr && val_ok && (qsel == CQD_QW'(i)))
        head_nxt[i] = new_head; // RULE5
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        head_r[i] <= CQD_HEAD_RST;
      else
        head_r[i] <= head_nxt[i];
    end

    assign completion_head_value[i] = head_r[i];
  end

  // Select register, events and responses
  always_comb
  begin
    sel_nxt = sel_r;
    if (io_sel_hit && io_req.write)
      sel_nxt = io_req.wdata & CQD_SEL_MASK; // RULE10 RULE16
    freed_nxt.valid = db_wr && val_ok;
    freed_nxt.qid = qsel;
    freed_nxt.freed = freed_cnt; // RULE6
    evt_nxt.valid = db_wr && !val_ok && aer_pending; // RULE15
    evt_nxt.qid = qsel;
    mrsp_nxt.valid = mmio_req.valid && !mmio_req.write && !io_win_hit;
    mrsp_nxt.rdata = acc_rdata;
    irsp_nxt.valid = io_req.valid && !io_req.write;
    if (io_sel_hit)
      irsp_nxt.rdata = sel_r & CQD_SEL_MASK; // RULE10
    else if (io_win_hit)
      irsp_nxt.rdata = acc_rdata; // RULE12 RULE13
    else
      irsp_nxt.rdata = 32'h0000_0000;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sel_r <= CQD_SELECT_RST;
      freed_r <= '0;
      evt_r <= '0;
      mrsp_r <= '0;
      irsp_r <= '0;
    end
    else
    begin
      sel_r <= sel_nxt;
      freed_r <= freed_nxt;
      evt_r <= evt_nxt;
      mrsp_r <= mrsp_nxt;
      irsp_r <= irsp_nxt;
    end
  end

  assign freed_o = freed_r;
  assign inv_db_o = evt_r;
  assign mmio_rsp = mrsp_r;
  assign io_rsp = irsp_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_good_db;
    db_wr && val_ok;
  endsequence

  sequence s_bad_db;
    db_wr && !val_ok;
  endsequence

  property p_head_update;
    logic [CQD_QW-1:0] q;
    logic [15:0] v;
    (s_good_db, q = qsel, v = new_head) |=> (completion_head_value[q] == v);
  endproperty
  a_head_update: assert property (p_head_update) else $error("head not replaced"); // RULE5

  property p_freed;
    s_good_db |=> freed_o.valid && (freed_o.freed == $past(freed_cnt)) && (freed_o.qid == $past(qsel));
  endproperty
  a_freed: assert property (p_freed) else $error("freed count wrong"); // RULE6

  property p_freed_bound;
    freed_o.valid |-> (freed_o.freed <= {1'b0, cq_size[freed_o.qid]});
  endproperty
  a_freed_bound: assert property (p_freed_bound) else $error("freed exceeds queue size"); // RULE14

  property p_sel_low;
    (sel_r[CQD_SEL_LSB-1:0] == 2'b00) && !(irsp_r.valid && irsp_r.rdata[1:0] != 2'b00 && $past(io_sel_hit));
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("select low bits set"); // RULE10 RULE16

  property p_sel_write;
    logic [31:0] w;
    (io_sel_hit && io_req.write, w = io_req.wdata & CQD_SEL_MASK) |=> (sel_r == w);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select not loaded"); // RULE10

  property p_window_fwd;
    io_win_hit |-> acc.valid && (acc.addr == sel_r) && (acc.write == io_req.write) && !mmio_ready;
  endproperty
  a_window_fwd: assert property (p_window_fwd) else $error("window not forwarded"); // RULE12

  property p_window_read;
    (io_win_hit && !io_req.write && !db_hit) |=> io_rsp.valid && (io_rsp.rdata == $past(ext_rdata));
  endproperty
  a_window_read: assert property (p_window_read) else $error("window read data wrong"); // RULE13

  property p_db_read;
    (db_hit && !acc.write && !io_win_hit) |=> mmio_rsp.valid && (mmio_rsp.rdata == CQD_DB_READ_VALUE);
  endproperty
  a_db_read: assert property (p_db_read) else $error("doorbell read value wrong"); // RULE2

  property p_db_decode;
    db_hit |-> !ext_req.valid && (acc.addr == CQD_DB_BASE + ((({qid_full[28:0], 3'b000}) + 32'h0000_0004)
      << doorbell_stride_field));
  endproperty
  a_db_decode: assert property (p_db_decode) else $error("doorbell decode wrong"); // RULE1

  property p_event;
    (s_bad_db ##0 aer_pending) |=> inv_db_o.valid && $stable(completion_head_value);
  endproperty
  a_event: assert property (p_event) else $error("invalid write event missing"); // RULE15

  property p_no_event;
    !(db_wr && aer_pending) |=> !inv_db_o.valid;
  endproperty
  a_no_event: assert property (p_no_event) else $error("spurious invalid write event"); // RULE15
endmodule

// >>> testbench/cq_doorbell_indirect_access_bench.sv
// Self-checking bench for the completion head doorbell and indirect pair block
module cq_doorbell_indirect_access_bench import cqd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic rst;
  cqd_req_t mmio_req;
  cqd_req_t io_req;
  cqd_req_t ext_req;
  logic mmio_ready;
  cqd_rsp_t mmio_rsp;
  cqd_rsp_t io_rsp;
  logic [31:0] ext_rdata;
  logic [3:0] stride;
  logic [CQD_NUM_CQ-1:0][15:0] cq_size;
  logic aer_pending;
  logic [CQD_NUM_CQ-1:0][15:0] head;
  cqd_free_t freed_o;
  cqd_evt_t inv_db_o;
  int n_mismatch = 0;
  int checks = 0;

  cqd_top dut_u (.clock(clock), .rst(rst), .mmio_req(mmio_req), .mmio_ready(mmio_ready),
    .mmio_rsp(mmio_rsp), .io_req(io_req), .io_rsp(io_rsp), .ext_req(ext_req), .ext_rdata(ext_rdata),
    .doorbell_stride_field(stride), .cq_size(cq_size), .aer_pending(aer_pending),
    .completion_head_value(head), .freed_o(freed_o), .inv_db_o(inv_db_o));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Raise one request at the falling edge
  task automatic start(input logic io, input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge clock);
    if (io)
      io_req = '{1'b1, wr, a, d};
    else
      mmio_req = '{1'b1, wr, a, d};
    #1;
  endtask

  // Drop requests; registered answers are visible on return
  task automatic fin;
    @(negedge clock);
    io_req = '0;
    mmio_req = '0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic t_reset;
    chk("head q3", CQD_HEAD_RST, head[3]);
    start(1'b1, 1'b0, CQD_IO_SELECT_OFF, 32'h0);
    fin;
    chk("select rsp valid", 32'h1, io_rsp.valid);
    chk("select read", CQD_SELECT_RST, io_rsp.rdata);
    start(1'b1, 1'b0, CQD_IO_WINDOW_OFF, 32'h0);
    chk("fwd valid", 32'h1, ext_req.valid);
    chk("fwd addr", 32'h0, ext_req.addr);
    chk("mmio ready", 32'h0, mmio_ready);
    fin;
    chk("window read", 32'h0040_0FFF, io_rsp.rdata);
  endtask

  task automatic t_head;
    start(1'b0, 1'b0, 32'h0000_1004, 32'h0);
    fin;
    chk("doorbell rsp valid", 32'h1, mmio_rsp.valid);
    chk("doorbell read", CQD_DB_READ_VALUE, mmio_rsp.rdata);
    start(1'b0, 1'b1, 32'h0000_100C, 32'h0000_0005);
    chk("db not fwd", 32'h0, ext_req.valid);
    fin;
    chk("head q1", 32'h5, head[1]);
    chk("freed valid", 32'h1, freed_o.valid);
    chk("freed qid", 32'h1, freed_o.qid);
    chk("freed", 32'h5, freed_o.freed);
    @(negedge clock);
    chk("freed pulse", 32'h0, freed_o.valid);
    start(1'b0, 1'b1, 32'h0000_100C, 32'hFFFF_0002);
    fin;
    chk("head q1 hi", 32'h2, head[1]);
    chk("freed wrap", 32'd13, freed_o.freed);
  endtask

  task automatic t_stride;
    stride = 4'h1;
    start(1'b0, 1'b1, 32'h0000_1028, 32'h0000_0006);
    fin;
    chk("head q2", 32'h6, head[2]);
    start(1'b0, 1'b1, 32'h0000_1020, 32'h0000_0001);
    chk("tail fwd", 32'h1, ext_req.valid);
    fin;
    stride = 4'h0;
  endtask

  task automatic t_invalid;
    aer_pending = 1'b1;
    start(1'b0, 1'b1, 32'h0000_1004, 32'h0000_0004);
    fin;
    chk("inv valid", 32'h1, inv_db_o.valid);
    chk("inv qid", 32'h0, inv_db_o.qid);
    chk("no freed", 32'h0, freed_o.valid);
    chk("head kept", 32'h0, head[0]);
    aer_pending = 1'b0;
    start(1'b0, 1'b1, 32'h0000_1004, 32'h0000_0009);
    fin;
    chk("inv quiet", 32'h0, inv_db_o.valid);
  endtask

  task automatic t_window;
    start(1'b1, 1'b1, CQD_IO_SELECT_OFF, 32'h0000_0123);
    fin;
    start(1'b1, 1'b0, CQD_IO_SELECT_OFF, 32'h0);
    fin;
    chk("select low bits", 32'h0000_0120, io_rsp.rdata);
    start(1'b1, 1'b1, CQD_IO_WINDOW_OFF, 32'hDEAD_BEEF);
    chk("fwd write", 32'h1, ext_req.write);
    chk("fwd addr", 32'h0000_0120, ext_req.addr);
    chk("fwd data", 32'hDEAD_BEEF, ext_req.wdata);
    fin;
    start(1'b1, 1'b1, CQD_IO_SELECT_OFF, 32'h0000_1004);
    fin;
    start(1'b1, 1'b1, CQD_IO_WINDOW_OFF, 32'h0000_0003);
    fin;
    chk("head via window", 32'h3, head[0]);
  endtask

  initial
  begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    report_and_stop;
  end

  initial
  begin
    rst = 1'b1;
    mmio_req = '0;
    io_req = '0;
    ext_rdata = 32'h0040_0FFF;
    stride = 4'h0;
    cq_size = {16'h000F, 16'h0007, 16'h000F, 16'h0003};
    aer_pending = 1'b0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    // Indirect phase only, then a fresh reset before direct access
    t_reset;
    t_window;
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk("head q0 after reset", CQD_HEAD_RST, head[0]);
    t_head;
    t_stride;
    t_invalid;
    report_and_stop;
  end
endmodule
